/* clk_src.sv */
/* partner: clock-pin source for the sequencer.
   assumes it is stepped by core_clk, changes 1 ns after a rising edge. */
`timescale 1ns/1ns
module clk_src (
  input  wire logic core_clk,
  input  wire logic run,
  output logic      clk_pin
);
  int n = 0;
  initial clk_pin = 1'b1;
  // ==========
  // source
  // stopped pin rests high, as the clamp holds it at the supply
  always @(posedge core_clk) begin
    #1;
    n = run ? n + 1 : 0;
    if (!run) clk_pin = 1'b1;
    else if (n >= (clk_pin ? 3 : 2)) begin
      clk_pin = ~clk_pin;
      n = 0;
    end
  end
endmodule

/* conv_seq.sv */
/*
  digital sequencer of an 8-bit successive-approximation converter:
  start detect, clock-pin divide by two, hold timing, cycle count,
  busy handshake, result latch and clock gating.
  assumes clk_pin is already synchronous to core_clk and at least one
  core clock per level; the sar result arrives on sar_result.
  limitation: a pin level shorter than one core clock may lose a fall,
  which stretches the conversion by one pin cycle.
  the clamp output is the same for internal and external clocking; the
  analog side decides whether it acts on it.
*/
// Behaviour
// - hold on third clock-pin falling edge after start
// - switch closed at start, input tracked
// - on finish switch closes, tracking resumes
// - internal clock is clock pin divided by two
// - conversion lasts 20 pin, 10 internal cycles
// - internal oscillator clamped off after conversion
// - ignore clock pin while idle
// - busy low during conversion
// - at end busy high, result latched
`timescale 1ns/1ns
`include "conv_seq_regs.svh"

module conv_seq #(
  parameter int DATA_W = 8
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire conv_seq_pkg::host_strobe_t strobe,
  input  wire logic                       clk_pin,
  input  wire logic [DATA_W-1:0]          sar_result,
  output logic                            busy_n,
  output logic                            sampling_switch,
  output logic                            timing_capacitor_clamp,
  output logic                            div_clk,
  output logic                            conv_done,
  output logic [DATA_W-1:0]               data_out
);

  // ===================================================================
  // parameter check
  // a result latch of no width cannot hold a code, so stop elaboration
  if (DATA_W < 1) begin : g_bad_width
    $error("DATA_W must be positive");
  end

  // ===================================================================
  // decode helpers
  // true on the pin fall that opens the hold phase
  function automatic logic hold_edge(input logic [3:0] falls_seen);
    return (falls_seen + 4'h1) == `HOLD_FALL_EDGE;
  endfunction

  // true on the pin fall that ends the conversion; the pin count and
  // the divided count must agree, so one skewed counter cannot cut a
  // conversion short
  function automatic logic final_edge(
    input logic [5:0] pin_seen,
    input logic [3:0] int_seen,
    input logic       div_now
  );
    return ((pin_seen + 6'h01) == `CONV_PIN_CYCLES) && div_now &&
           ((int_seen + 4'h1) == `CONV_INT_CYCLES);
  endfunction

  // ===================================================================
  // start detection
  logic start_req;
  logic strobe_low_q;
  logic strobe_low_d;

  assign strobe_low_d = !strobe.cs_n && !strobe.rd_n;
  // a conversion begins on the edge where both strobes become low; a
  // host that keeps them low through completion starts nothing more.
  // a strobe edge close to a pin fall may or may not count that fall,
  // so the host keeps its strobes away from falls when timing matters
  assign start_req = strobe_low_d && !strobe_low_q;

  // ===================================================================
  // sequencing state
  conv_seq_pkg::seq_state_t  state_q;
  conv_seq_pkg::seq_state_t  state_d;
  // status flops travel together; each output but data_out is one member
  conv_seq_pkg::seq_status_t stat_q;
  conv_seq_pkg::seq_status_t stat_d;
  logic                      pin_q;
  logic                      pin_d;
  // falls up to the hold edge, all pin falls, divided cycles
  logic [3:0]                fall_cnt_q;
  logic [3:0]                fall_cnt_d;
  logic [5:0]                pin_cyc_q;
  logic [5:0]                pin_cyc_d;
  logic [3:0]                int_cyc_q;
  logic [3:0]                int_cyc_d;
  logic [DATA_W-1:0]         data_q;
  logic [DATA_W-1:0]         data_d;
  logic                      pin_fall;

  // ===================================================================
  // clock-pin edge
  // the pin is sampled every core clock; a fall is a one then a zero.
  // pin edges only matter while converting, so idle toggles are dropped
  // by the state machine rather than gated here
  assign pin_fall = pin_q && !clk_pin;

  // ===================================================================
  // next-state logic
  always_comb begin
    state_d           = state_q;
    stat_d            = stat_q;
    stat_d.latch_load = 1'b0;
    pin_d             = clk_pin;
    fall_cnt_d        = fall_cnt_q;
    pin_cyc_d         = pin_cyc_q;
    int_cyc_d         = int_cyc_q;
    data_d            = data_q;
    unique case (state_q)
      conv_seq_pkg::ST_IDLE, conv_seq_pkg::ST_DONE: begin
        state_d                = conv_seq_pkg::ST_IDLE;
        stat_d.div_clk         = 1'b0;
        stat_d.sampling_switch = 1'b1;
        if (start_req) begin
          state_d          = conv_seq_pkg::ST_CONV;
          fall_cnt_d       = 4'h0;
          pin_cyc_d        = 6'h00;
          int_cyc_d        = 4'h0;
          stat_d.div_clk   = 1'b0;
          stat_d.busy_n    = 1'b0;
          stat_d.osc_clamp = 1'b0;
        end
      end
      conv_seq_pkg::ST_CONV: begin
        // starts seen here are dropped: no retrigger mid conversion
        if (pin_fall) begin
          stat_d.div_clk = !stat_q.div_clk;
          pin_cyc_d      = pin_cyc_q + 6'h01;
          if (stat_q.div_clk) begin
            int_cyc_d = int_cyc_q + 4'h1;
          end
          // saturate so the hold edge is decoded once per conversion
          if (fall_cnt_q != `HOLD_FALL_EDGE) begin
            fall_cnt_d = fall_cnt_q + 4'h1;
          end
          if (hold_edge(fall_cnt_q)) begin
            stat_d.sampling_switch = 1'b0;
          end
          if (final_edge(pin_cyc_q, int_cyc_q, stat_q.div_clk)) begin
            // final divided cycle reached: end the conversion
            state_d                = conv_seq_pkg::ST_DONE;
            stat_d.sampling_switch = 1'b1;
            stat_d.busy_n          = 1'b1;
            stat_d.osc_clamp       = 1'b1;
            stat_d.div_clk         = 1'b0;
            stat_d.latch_load      = 1'b1;
            data_d                 = sar_result;
          end
        end
      end
      default: begin
        state_d = conv_seq_pkg::ST_IDLE;
      end
    endcase
  end

  // ===================================================================
  // state registers
  // reset leaves the switch closed and the pin clamped, so an idle
  // converter tracks its input and its oscillator stays stopped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q                <= conv_seq_pkg::ST_IDLE;
      strobe_low_q           <= 1'b0;
      pin_q                  <= 1'b1;
      fall_cnt_q             <= 4'h0;
      pin_cyc_q              <= 6'h00;
      int_cyc_q              <= 4'h0;
      stat_q.busy_n          <= 1'b1;
      stat_q.sampling_switch <= 1'b1;
      stat_q.osc_clamp       <= 1'b1;
      stat_q.div_clk         <= 1'b0;
      stat_q.latch_load      <= 1'b0;
      data_q                 <= DATA_W'(`RESULT_RESET);
    end else begin
      state_q                <= state_d;
      strobe_low_q           <= strobe_low_d;
      pin_q                  <= pin_d;
      fall_cnt_q             <= fall_cnt_d;
      pin_cyc_q              <= pin_cyc_d;
      int_cyc_q              <= int_cyc_d;
      stat_q                 <= stat_d;
      data_q                 <= data_d;
    end
  end

  // ===================================================================
  // outputs, each straight from a register
  assign busy_n                 = stat_q.busy_n;
  assign sampling_switch        = stat_q.sampling_switch;
  assign timing_capacitor_clamp = stat_q.osc_clamp;
  assign div_clk                = stat_q.div_clk;
  assign conv_done              = stat_q.latch_load;
  assign data_out               = data_q;

endmodule

/* conv_seq_pkg.sv */
/*
  types shared by the conversion clock sequencer.
  assumes conv_seq_regs.svh holds the numeric constants.
*/
package conv_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONV,
    ST_DONE
  } seq_state_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
  } host_strobe_t;

  typedef struct packed {
    logic busy_n;
    logic sampling_switch;
    logic osc_clamp;
    logic div_clk;
    logic latch_load;
  } seq_status_t;

endpackage

/* conv_seq_regs.svh */
/*
  timing constants and counts for the conversion clock sequencer.
  assumes inclusion by bare name from the sequencer module.
*/
`ifndef CONV_SEQ_REGS_SVH
`define CONV_SEQ_REGS_SVH

// =====================================================================
// conversion timing
`define HOLD_FALL_EDGE       4'h3
`define CONV_PIN_CYCLES      6'h14
`define CONV_DIV_FACTOR      2
`define CONV_INT_CYCLES      4'hA
`define STROBE_GUARD_NS      20
`define CORE_CLK_NS          20
`define STROBE_GUARD_CYC     ((`STROBE_GUARD_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define RESULT_RESET         8'h00

`endif

/* conv_seq_sva.sv */
/* checker: port rules of conv_seq. assumes bind onto conv_seq. */
`timescale 1ns/1ns
module conv_seq_sva (
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire conv_seq_pkg::host_strobe_t strobe,
  input wire logic                       clk_pin,
  input wire logic                       busy_n,
  input wire logic                       sampling_switch,
  input wire logic                       timing_capacitor_clamp,
  input wire logic                       div_clk
);
  logic [4:0] n_q;
  logic [4:0] n_d;
  logic       pin_q;
  logic       fall;
  logic       fin;
  // ==========
  // fall counter, cleared whenever idle
  assign fall = pin_q & ~clk_pin;
  assign fin = ~busy_n & fall & (n_q == 5'h13);
  always_comb n_d = busy_n ? 5'h00 : n_q + {4'h0, fall};
  always_ff @(posedge core_clk) begin
    n_q <= rst_n ? n_d : 5'h00;
    pin_q <= clk_pin;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_busy_start: assert property (strobe == 2'b00 &&
    $past(strobe) != 2'b00 && busy_n |=> !busy_n) else $error("no busy");
  chk_busy_hold: assert property (!busy_n && !fin |=> !busy_n)
    else $error("busy ended early");
  chk_done_at_20: assert property (fin |=> busy_n)
    else $error("no finish on 20th fall");
  chk_hold_third: assert property (!busy_n && fall && n_q == 5'h02
    |=> !sampling_switch) else $error("hold edge wrong");
  chk_track_phase: assert property (busy_n || n_q < 5'h03
    |-> sampling_switch) else $error("switch open early");
  chk_clamp_idle: assert property (timing_capacitor_clamp == busy_n)
    else $error("clamp wrong");
  chk_idle_div: assert property (busy_n |-> !div_clk)
    else $error("divider runs idle");
  chk_div_half: assert property (!busy_n && !fin
    |=> (div_clk ^ $past(div_clk)) == $past(fall)) else $error("bad divide");
endmodule
bind conv_seq conv_seq_sva u_sva (.*);

/* testbench.sv */
/* bench: conv_seq with its clock-pin source. assumes 50 MHz core_clk. */
`timescale 1ns/1ns
module testbench;
  logic                       core_clk = 1'b0;
  logic                       rst_n = 1'b0;
  conv_seq_pkg::host_strobe_t strobe = 2'b11;
  logic                       ext = 1'b0;
  logic [7:0]                 sar_result = 8'h00;
  logic [7:0]                 data_out;
  logic clk_pin, busy_n, sampling_switch, timing_capacitor_clamp;
  logic div_clk, conv_done;
  int n_errors = 0;
  int check_count = 0;
  always #10 core_clk = ~core_clk;
  clk_src u_src (.core_clk, .run(ext | ~timing_capacitor_clamp), .clk_pin);
  conv_seq DUT (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .strobe                 (strobe),
    .clk_pin                (clk_pin),
    .sar_result             (sar_result),
    .busy_n                 (busy_n),
    .sampling_switch        (sampling_switch),
    .timing_capacitor_clamp (timing_capacitor_clamp),
    .div_clk                (div_clk),
    .conv_done              (conv_done),
    .data_out               (data_out)
  );
  // ==========
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // start away from a pin fall, optionally poking strobes mid-run
  task automatic conv(input logic [7:0] v, input bit poke);
    int i;
    sar_result = v;
    for (i = 0; i < 9 && ext && clk_pin !== 1'b0; i++) begin
      @(posedge core_clk);
      #2;
    end
    if (i == 9) begin
      n_errors++;
      wrap_up();
    end
    strobe = 2'b00;
    for (i = 0; i < 400 && conv_done !== 1'b1; i++) begin
      @(posedge core_clk);
      #2;
      if (poke) strobe = (i == 30) ? 2'b11 : 2'b00;
    end
    if (i == 400) begin
      n_errors++;
      wrap_up();
    end
    chk(data_out, v);
    chk({4'h0, busy_n, sampling_switch, timing_capacitor_clamp, div_clk},
        8'h0E);
    strobe = 2'b11;
    @(posedge core_clk);
    #2;
    chk({7'h00, conv_done}, 8'h00);
    repeat (12) begin
      @(posedge core_clk);
      #2;
      chk({6'h00, div_clk, ~busy_n}, 8'h00);
    end
  endtask
  // ==========
  // scenarios
  task automatic scn_reset();
    repeat (16) @(posedge core_clk);
    #2;
    chk({3'h0, busy_n, sampling_switch, timing_capacitor_clamp, div_clk,
        conv_done}, 8'h1C);
    chk(data_out, 8'h00);
    rst_n = 1'b1;
  endtask
  task automatic scn_mid_reset();
    strobe = 2'b00;
    repeat (40) begin
      @(posedge core_clk);
      #2;
    end
    chk({6'h00, busy_n, sampling_switch}, 8'h00);
    rst_n = 1'b0;
    strobe = 2'b11;
    repeat (2) begin
      @(posedge core_clk);
      #2;
    end
    chk({3'h0, busy_n, sampling_switch, timing_capacitor_clamp, div_clk,
        conv_done}, 8'h1C);
    chk(data_out, 8'h00);
    rst_n = 1'b1;
    repeat (2) begin
      @(posedge core_clk);
      #2;
      chk({3'h0, busy_n, sampling_switch, timing_capacitor_clamp, div_clk,
          conv_done}, 8'h1C);
    end
  endtask
  task automatic scn_external();
    ext = 1'b1;
    conv(8'h5A, 1'b1);
    conv(8'hFF, 1'b0);
  endtask
  initial begin
    scn_reset();
    conv(8'hA5, 1'b0);
    scn_mid_reset();
    scn_external();
    wrap_up();
  end
endmodule
